// *** csfr_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module csfr_core (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // register port
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [7:0]             rdata,
  // instruction execution
  input  wire logic              exec,
  input  wire csfr_pkg::csfr_op_t alu_op,
  input  wire logic [7:0]        alu_a,
  input  wire logic [7:0]        alu_b,
  input  wire logic              affects_z,
  input  wire logic              affects_cdc,
  input  wire logic              clear_register_instr,
  input  wire logic [7:0]        dest_addr,
  output logic [7:0]             alu_result,
  // hardware events
  input  wire logic              sleep_instr,
  input  wire logic              watchdog_clear_instr,
  input  wire logic              watchdog_timeout,
  // banking and prescaler
  output logic [8:0]             direct_bank_base,
  output logic                   indirect_upper_pair,
  output logic                   prescale_to_timer,
  output logic                   prescale_to_watchdog,
  output logic                   first_timer_undivided
);
  import csfr_pkg::*;

  logic       rst_s1_q;
  logic       rst_s2_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] opts_q;
  logic [7:0] opts_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [8:0] base_q;
  logic [8:0] base_d;
  logic       ind_bank_q;
  logic       ind_bank_d;
  logic       psa_q;
  logic       psa_d;

  csfr_alu_if alu_bus ();

  csfr_alu u_alu (
    .bus (alu_bus.alu)
  );

  assign alu_bus.op       = exec ? alu_op : CSFR_OP_NONE;
  assign alu_bus.a        = alu_a;
  assign alu_bus.b        = alu_b;
  assign alu_bus.carry_in = flags_q[CSFR_BIT_CARRY];

  // reset release through two stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  logic dest_flags;
  logic [7:0] wmask;
  logic [7:0] wval;
  always_comb begin
    flags_d  = flags_q;
    opts_d   = opts_q;
    result_d = result_q;
    wmask    = 8'h00;
    wval     = wdata;
    dest_flags = exec && (dest_addr == CSFR_ADDR_FLAGS);
    // instruction result lands in any register, flags included
    if (exec) begin
      result_d = clear_register_instr ? 8'h00 : alu_bus.result;
    end
    // alu flag updates
    if (exec && affects_z) begin
      flags_d[CSFR_BIT_ZERO] = clear_register_instr ? 1'b1 : alu_bus.zero;
    end
    if (exec && affects_cdc) begin
      flags_d[CSFR_BIT_CARRY]  = alu_bus.carry;
      flags_d[CSFR_BIT_NIBBLE] = alu_bus.nibble;
    end
    if (dest_flags) begin
      wval  = clear_register_instr ? 8'h00 : alu_bus.result;
      // start fully writable, then block what the alu owns
      wmask = 8'hFF;
      if (affects_z) begin
        wmask[CSFR_BIT_ZERO] = 1'b0;
      end
      if (affects_cdc) begin
        wmask[CSFR_BIT_NIBBLE] = 1'b0;
        wmask[CSFR_BIT_CARRY]  = 1'b0;
      end
      if (clear_register_instr) begin
        wmask = CSFR_WMASK_ARITH & ~CSFR_WMASK_CLEAR;
        flags_d[CSFR_BIT_ZERO] = 1'b1;
      end
    end else if (wr && addr == CSFR_ADDR_FLAGS) begin
      wmask = 8'hFF;
    end
    wmask[CSFR_BIT_TMOUT] = 1'b0;
    wmask[CSFR_BIT_PWRDN] = 1'b0;
    flags_d = (flags_d & ~wmask) | (wval & wmask);
    if (exec && (dest_addr == CSFR_ADDR_OPTIONS)) begin
      opts_d = clear_register_instr ? 8'h00 : alu_bus.result;
    end else if (wr && addr == CSFR_ADDR_OPTIONS) begin
      opts_d = wdata;
    end
    // hardware-only reset-cause updates win over writes
    if (sleep_instr) begin
      flags_d[CSFR_BIT_PWRDN] = 1'b0;
      flags_d[CSFR_BIT_TMOUT] = 1'b1;
    end
    if (watchdog_clear_instr) begin
      flags_d[CSFR_BIT_PWRDN] = 1'b1;
      flags_d[CSFR_BIT_TMOUT] = 1'b1;
    end
    if (watchdog_timeout) begin
      flags_d[CSFR_BIT_TMOUT] = 1'b0;
    end
  end

  always_comb begin
    // direct bank: code times bank size
    base_d = {flags_d[CSFR_BIT_BANK_HI], flags_d[CSFR_BIT_BANK_LO], 7'h00};
    ind_bank_d = flags_d[CSFR_BIT_IND_BANK];
    psa_d  = opts_d[CSFR_BIT_PSA];
    rdata_d = 8'h00;
    if (rd) begin
      unique case (addr)
        CSFR_ADDR_FLAGS:   rdata_d = flags_q;
        CSFR_ADDR_OPTIONS: rdata_d = opts_q;
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // power-up leaves timeout and power-down set
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      flags_q  <= CSFR_FLAGS_RESET;
      opts_q   <= CSFR_OPTIONS_RESET;
      rdata_q  <= 8'h00;
      result_q <= 8'h00;
      base_q   <= 9'h000;
      ind_bank_q <= 1'b0;
      psa_q    <= 1'b1;
    end else begin
      flags_q  <= flags_d;
      opts_q   <= opts_d;
      rdata_q  <= rdata_d;
      result_q <= result_d;
      base_q   <= base_d;
      ind_bank_q <= ind_bank_d;
      psa_q    <= psa_d;
    end
  end

  assign rdata                 = rdata_q;
  assign alu_result            = result_q;
  assign direct_bank_base      = base_q;
  assign indirect_upper_pair   = ind_bank_q;
  // single prescaler, never both at once
  assign prescale_to_watchdog  = psa_q;
  assign prescale_to_timer     = ~psa_q;
  assign first_timer_undivided = psa_q;
endmodule // csfr_core
`default_nettype wire

// *** csfr_pkg.sv ***
package csfr_pkg;
  // register map, plain port addresses
  localparam logic [7:0] CSFR_ADDR_FLAGS   = 8'h03;
  localparam logic [7:0] CSFR_ADDR_OPTIONS = 8'h81;
  // flag register fields
  localparam int CSFR_BIT_CARRY  = 0;
  localparam int CSFR_BIT_NIBBLE = 1;
  localparam int CSFR_BIT_ZERO   = 2;
  localparam int CSFR_BIT_PWRDN    = 3;
  localparam int CSFR_BIT_TMOUT    = 4;
  localparam int CSFR_BIT_BANK_LO  = 5;
  localparam int CSFR_BIT_BANK_HI  = 6;
  localparam int CSFR_BIT_IND_BANK = 7;
  // option register fields
  localparam int CSFR_BIT_PSA    = 3;
  localparam logic [7:0] CSFR_FLAGS_RESET   = 8'h18;
  localparam logic [7:0] CSFR_OPTIONS_RESET = 8'hFF;
  localparam logic [7:0] CSFR_WMASK_ARITH   = 8'hF8;
  localparam logic [7:0] CSFR_WMASK_CLEAR   = 8'h1F;
  localparam logic [7:0] CSFR_BANK_SIZE     = 8'h80;
  // alu operations
  typedef enum logic [2:0] {
    CSFR_OP_NONE = 3'b000,
    CSFR_OP_ADD  = 3'b001,
    CSFR_OP_SUB  = 3'b010,
    CSFR_OP_RLF  = 3'b011,
    CSFR_OP_RRF  = 3'b100,
    CSFR_OP_LOGIC = 3'b101
  } csfr_op_t;
endpackage

// *** csfr_alu_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface csfr_alu_if;
  import csfr_pkg::*;
  csfr_op_t   op;
  logic [7:0] a;
  logic [7:0] b;
  logic       carry_in;
  logic [7:0] result;
  logic       carry;
  logic       nibble;
  logic       zero;
  modport core (output op, a, b, carry_in, input result, carry, nibble, zero);
  modport alu  (input op, a, b, carry_in, output result, carry, nibble, zero);
endinterface
`default_nettype wire

// *** csfr_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module csfr_alu (
  csfr_alu_if.alu bus
);
  import csfr_pkg::*;
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] opb;
  logic       cin;
  always_comb begin
    // subtraction adds the complement, so carry means no borrow
    opb = (bus.op == CSFR_OP_SUB) ? ~bus.b : bus.b;
    cin = (bus.op == CSFR_OP_SUB);
    sum = {1'b0, bus.a} + {1'b0, opb} + {8'h00, cin};
    low = {1'b0, bus.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    bus.result = sum[7:0];
    bus.carry  = sum[8];
    bus.nibble = low[4];
    unique case (bus.op)
      CSFR_OP_RLF: begin
        bus.result = {bus.a[6:0], bus.carry_in};
        bus.carry  = bus.a[7];
      end
      CSFR_OP_RRF: begin
        bus.result = {bus.carry_in, bus.a[7:1]};
        bus.carry  = bus.a[0];
      end
      CSFR_OP_LOGIC: bus.result = bus.a & bus.b;
      default: ;
    endcase
    bus.zero = (bus.result == 8'h00);
  end
endmodule // csfr_alu
`default_nettype wire

// *** csfr_core_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module csfr_core_assertions
  import csfr_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // register port
  input wire logic [7:0]         addr,
  input wire logic [7:0]         wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [7:0]         rdata,
  // instruction execution
  input wire logic               exec,
  input wire csfr_pkg::csfr_op_t alu_op,
  input wire logic [7:0]         alu_a,
  input wire logic [7:0]         alu_b,
  input wire logic               clear_register_instr,
  input wire logic [7:0]         dest_addr,
  input wire logic [7:0]         alu_result,
  // banking and prescaler
  input wire logic [8:0]         direct_bank_base,
  input wire logic               indirect_upper_pair,
  input wire logic               prescale_to_timer,
  input wire logic               prescale_to_watchdog,
  input wire logic               first_timer_undivided
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_add_result: assert property (exec && alu_op == CSFR_OP_ADD |=>
    alu_result == $past(alu_a + alu_b)) else $error("add result wrong");
  chk_psa_split: assert property (prescale_to_timer != prescale_to_watchdog)
    else $error("prescaler owner wrong");
  chk_timer_undiv: assert property (first_timer_undivided == prescale_to_watchdog)
    else $error("timer rate wrong");
  chk_bank_align: assert property (direct_bank_base[6:0] == 7'h00)
    else $error("bank base misaligned");
  // ##2: bank outputs are registered from flags_d, so they change on the same edge as the flag flops
  chk_wr_bank: assert property (wr && !exec && addr == CSFR_ADDR_FLAGS |-> ##2
    direct_bank_base[8:7] == $past(wdata[6:5], 2)) else $error("direct bank wrong");
  chk_wr_indirect: assert property (wr && !exec && addr == CSFR_ADDR_FLAGS |-> ##2
    indirect_upper_pair == $past(wdata[7], 2)) else $error("indirect bank wrong");
  chk_clear_bank: assert property (exec && clear_register_instr && dest_addr == 8'h03
    |-> ##2 direct_bank_base == 9'h000 && !indirect_upper_pair) else $error("clear kept bank");
endmodule // csfr_core_assertions
bind csfr_core csfr_core_assertions u_chk (.*);
`default_nettype wire

// *** core_status_flag_register_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_status_flag_register_bench;
  import csfr_pkg::*;
  logic       clk, nrst, wr, rd, exec, affects_z, affects_cdc, clear_register_instr;
  logic       sleep_instr, watchdog_clear_instr, watchdog_timeout, indirect_upper_pair;
  logic       prescale_to_timer, prescale_to_watchdog, first_timer_undivided;
  logic [7:0] addr, wdata, rdata, alu_a, alu_b, dest_addr, alu_result;
  logic [8:0] direct_bank_base;
  csfr_op_t   alu_op;
  int         err_total, num_checks;
  csfr_core u_dut (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task cmp(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp({2'b00, rdata}, {2'b00, e});
  endtask
  // f: affects zero, affects carries, clear
  task ex(input csfr_op_t op, input logic [7:0] a, b, input logic [2:0] f, input logic [7:0] d);
    @(posedge clk);
    {exec, alu_a, alu_b, dest_addr} <= {1'b1, a, b, d};
    alu_op <= op;
    {affects_z, affects_cdc, clear_register_instr} <= f;
    @(posedge clk);
    exec <= 1'b0;
  endtask
  task ev(input logic [2:0] v);
    @(posedge clk);
    {sleep_instr, watchdog_clear_instr, watchdog_timeout} <= v;
    @(posedge clk);
    {sleep_instr, watchdog_clear_instr, watchdog_timeout} <= 3'b000;
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    final_report();
  end
  initial begin
    {nrst, wr, rd, exec, affects_z, affects_cdc, clear_register_instr} = '0;
    {sleep_instr, watchdog_clear_instr, watchdog_timeout} = '0;
    {addr, wdata, alu_a, alu_b, dest_addr} = '0;
    alu_op = CSFR_OP_NONE;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(CSFR_ADDR_FLAGS, 8'h18);
    rdc(CSFR_ADDR_OPTIONS, 8'hFF);
    rdc(8'h55, 8'h00);
    cmp({7'h00, prescale_to_watchdog, first_timer_undivided, prescale_to_timer}, 10'h006);
    $display("test reset done");
    wrr(CSFR_ADDR_FLAGS, 8'h00);
    rdc(CSFR_ADDR_FLAGS, 8'h18);
    wrr(CSFR_ADDR_FLAGS, 8'hE7);
    @(posedge clk);
    #1 cmp({indirect_upper_pair, direct_bank_base}, 10'h380);
    rdc(CSFR_ADDR_FLAGS, 8'hFF);
    wrr(CSFR_ADDR_FLAGS, 8'h40);
    @(posedge clk);
    #1 cmp({indirect_upper_pair, direct_bank_base}, 10'h100);
    wrr(CSFR_ADDR_OPTIONS, 8'hF7);
    rdc(CSFR_ADDR_OPTIONS, 8'hF7);
    cmp({7'h00, prescale_to_watchdog, first_timer_undivided, prescale_to_timer}, 10'h001);
    $display("test write masks done");
    wrr(CSFR_ADDR_FLAGS, 8'hE2);
    ex(CSFR_OP_NONE, 8'h00, 8'h00, 3'b101, CSFR_ADDR_FLAGS);
    rdc(CSFR_ADDR_FLAGS, 8'h1E);
    ex(CSFR_OP_ADD, 8'hFF, 8'h01, 3'b110, CSFR_ADDR_FLAGS);
    rdc(CSFR_ADDR_FLAGS, 8'h1F);
    wrr(CSFR_ADDR_FLAGS, 8'h00);
    ex(CSFR_OP_SUB, 8'h37, 8'h37, 3'b110, 8'h20);
    #1 cmp({2'b00, alu_result}, 10'h000);
    rdc(CSFR_ADDR_FLAGS, 8'h1F);
    wrr(CSFR_ADDR_FLAGS, 8'h00);
    ex(CSFR_OP_RLF, 8'h80, 8'h80, 3'b010, 8'h20);
    rdc(CSFR_ADDR_FLAGS, 8'h19);
    ex(CSFR_OP_RRF, 8'h02, 8'h02, 3'b010, 8'h20);
    #1 cmp({2'b00, alu_result}, 10'h081);
    rdc(CSFR_ADDR_FLAGS, 8'h18);
    ex(CSFR_OP_LOGIC, 8'h0F, 8'hF0, 3'b000, 8'h20);
    rdc(CSFR_ADDR_FLAGS, 8'h18);
    $display("test alu flags done");
    ev(3'b001);
    rdc(CSFR_ADDR_FLAGS, 8'h08);
    ev(3'b100);
    rdc(CSFR_ADDR_FLAGS, 8'h10);
    ev(3'b010);
    rdc(CSFR_ADDR_FLAGS, 8'h18);
    $display("test reset cause done");
    final_report();
  end
endmodule // core_status_flag_register_bench
`default_nettype wire
